// [hw/scwfc_link_if.sv]
/*
  Carrier between the frame controller and its bit shifter.
  Assumes both ends run on the same aclk.
*/
`timescale 1ns/1ns
interface scwfc_link_if;
  logic        start;
  logic        abort;
  logic [31:0] word;
  logic [5:0]  nbits;
  logic        mask;
  logic        done;
  logic [31:0] rx_word;

  modport ctrl (output start, abort, word, nbits, mask, input done, rx_word);
  modport eng  (input start, abort, word, nbits, mask, output done, rx_word);
endinterface

// [hw/scwfc_pkg.sv]
/*
  Constants and types for the serial command-word frame controller.
  Assumes a 20 MHz aclk and a 32-bit AXI4-Lite register port.
*/
package scwfc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned SCK_PERIOD_NS = 400;
  localparam logic [7:0]  SCK_HALF_CYC  = 8'(SCK_PERIOD_NS / (2 * CLK_PERIOD_NS));
  localparam logic [7:0]  SCK_HALF_LAST = SCK_HALF_CYC - 8'h01;

  localparam logic [7:0] ADDR_CTRL                      = 8'h00;
  localparam logic [7:0] ADDR_STATUS_REGISTER           = 8'h04;
  localparam logic [7:0] ADDR_IRQ_MASK                  = 8'h08;
  localparam logic [7:0] ADDR_TRANSMIT_COMMAND_REGISTER = 8'h0C;
  localparam logic [7:0] ADDR_TX_DATA                   = 8'h10;
  localparam logic [7:0] ADDR_RX_DATA                   = 8'h14;

  localparam int FRAME_SIZE_FIELD_LSB    = 0;
  localparam int FRAME_SIZE_FIELD_W      = 12;
  localparam int CONTINUOUS_TRANSFER_BIT = 20;
  localparam int TRANSMIT_MASK_BIT       = 22;
  localparam logic [31:0] CMD_RST        = 32'h0000_001F;

  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_SWRST_BIT = 1;

  localparam int NUM_EVENTS     = 3;
  localparam int STS_FRAME_DONE = 0;
  localparam int STS_RX_ERR     = 1;
  localparam int STS_TX_OVF     = 2;
  localparam int STS_BUSY       = 8;
  localparam int STS_CS_ACTIVE  = 9;
  localparam int STS_FIFO_FULL  = 10;

  localparam int FIFO_AW = 2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_CHUNK, ST_SHIFT} scwfc_state_e;
endpackage

// [hw/scwfc_shifter.sv]
/*
  Shifts one chunk of up to 32 bits, MSB first, mode 0 timing.
  Assumes the word is left aligned and start comes only while idle.
*/
`timescale 1ns/1ns
module scwfc_shifter (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic sdi,
  output logic      sck,
  output logic      sdo,
  output logic      sdo_oe,
  scwfc_link_if.eng lnk
);
  logic        sdi_meta_reg;
  logic        sdi_sync_reg;
  logic        busy_reg;
  logic [31:0] tx_reg;
  logic [31:0] rx_reg;
  logic [5:0]  nbits_reg;
  logic [5:0]  bit_reg;
  logic [7:0]  div_reg;

  assign sdo = tx_reg[31];

  always_ff @(posedge aclk)
  begin
    sdi_meta_reg <= sdi;
    sdi_sync_reg <= sdi_meta_reg;
  end

  always_ff @(posedge aclk)
  begin
    lnk.done <= 1'b0;
    if (!aresetn || lnk.abort)
    begin
      busy_reg    <= 1'b0;
      sck         <= 1'b0;
      sdo_oe      <= 1'b0;
      tx_reg      <= 32'h0000_0000;
      rx_reg      <= 32'h0000_0000;
      nbits_reg   <= 6'h00;
      bit_reg     <= 6'h00;
      div_reg     <= 8'h00;
      lnk.rx_word <= 32'h0000_0000;
    end
    else if (!busy_reg)
    begin
      if (lnk.start)
      begin
        busy_reg  <= 1'b1;
        tx_reg    <= lnk.word;
        rx_reg    <= 32'h0000_0000;
        nbits_reg <= lnk.nbits;
        sdo_oe    <= !lnk.mask;
        bit_reg   <= 6'h00;
        div_reg   <= 8'h00;
      end
    end
    else if (div_reg == scwfc_pkg::SCK_HALF_LAST)
    begin
      div_reg <= 8'h00;
      if (!sck)
      begin
        sck    <= 1'b1;
        rx_reg <= {rx_reg[30:0], sdi_sync_reg};
      end
      else
      begin
        sck     <= 1'b0;
        tx_reg  <= {tx_reg[30:0], 1'b0};
        bit_reg <= bit_reg + 6'h01;
        if (bit_reg + 6'h01 == nbits_reg)
        begin
          busy_reg    <= 1'b0;
          sdo_oe      <= 1'b0;
          lnk.done    <= 1'b1;
          lnk.rx_word <= rx_reg;
        end
      end
    end
    else
    begin
      div_reg <= div_reg + 8'h01;
    end
  end
endmodule

// [hw/scwfc_top.sv]
/*
  Serial command-word frame controller, master end, AXI4-Lite slave.
  Assumes aclk at 20 MHz, sdi asynchronous, one external device on chip select.
*/
`timescale 1ns/1ns
module scwfc_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             sck,
  output logic             peripheral_chip_select_n,
  output logic             sdo,
  output logic             sdo_oe,
  input  wire logic        sdi,
  output logic             irq
);
  localparam int FW = scwfc_pkg::FRAME_SIZE_FIELD_W;
  localparam int NE = scwfc_pkg::NUM_EVENTS;
  localparam int AW = scwfc_pkg::FIFO_AW;

  scwfc_link_if lnk ();

  logic                 aw_got_reg;
  logic                 w_got_reg;
  logic [7:0]           awaddr_reg;
  logic [31:0]          wdata_reg;
  logic [3:0]           wstrb_reg;
  logic                 wr_fire;
  logic                 wr_fifo;
  logic                 wr_map;
  logic                 push;
  logic                 srst;
  logic                 rd_fire;
  logic                 rd_rdr;
  logic [31:0]          rd_data;
  logic                 rd_ok;
  logic                 ctrl_en_reg;
  logic                 en_d_reg;
  logic                 en_rise;
  logic [NE-1:0]        status_reg;
  logic [NE-1:0]        irq_mask_reg;
  logic [NE-1:0]        ev;
  logic [NE-1:0]        w1c;
  logic [32:0]          fifo_mem [0:(1<<AW)-1];
  logic [AW:0]          wr_ptr_reg;
  logic [AW:0]          rd_ptr_reg;
  logic [32:0]          fifo_head;
  logic                 fifo_empty;
  logic                 fifo_full;
  scwfc_pkg::scwfc_state_e st_reg;
  logic [31:0]          cmd_reg;
  logic                 cmd_mask;
  logic                 cmd_cont;
  logic [FW:0]          frame_bits;
  logic [FW:0]          bits_left_reg;
  logic [5:0]           chunk_reg;
  logic [5:0]           n_chunk;
  logic                 cs_n_reg;
  logic                 pop_cmd;
  logic                 start_frame;
  logic                 chunk_go;
  logic                 pop_data;
  logic                 frame_end;
  logic [31:0]          rdr_reg;
  logic                 rdr_full_reg;
  logic                 rx_seen_reg;

  // Register port
  assign s_axi_awready = !aw_got_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire = aw_got_reg && w_got_reg && !s_axi_bvalid;
  assign wr_fifo = (awaddr_reg == scwfc_pkg::ADDR_TRANSMIT_COMMAND_REGISTER)
                || (awaddr_reg == scwfc_pkg::ADDR_TX_DATA);
  assign wr_map  = wr_fifo || (awaddr_reg == scwfc_pkg::ADDR_CTRL)
                || (awaddr_reg == scwfc_pkg::ADDR_STATUS_REGISTER)
                || (awaddr_reg == scwfc_pkg::ADDR_IRQ_MASK);
  // Full queue refuses the word; software sees SLVERR and an overflow flag
  assign push = wr_fire && wr_fifo && !fifo_full;
  assign srst = wr_fire && (awaddr_reg == scwfc_pkg::ADDR_CTRL) && wstrb_reg[0]
             && wdata_reg[scwfc_pkg::CTRL_SWRST_BIT];
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_rdr  = rd_fire && (s_axi_araddr == scwfc_pkg::ADDR_RX_DATA);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_reg   <= 1'b0;
      w_got_reg    <= 1'b0;
      awaddr_reg   <= 8'h00;
      wdata_reg    <= 32'h0000_0000;
      wstrb_reg    <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= scwfc_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_got_reg   <= 1'b0;
        w_got_reg    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_map && !(wr_fifo && fifo_full)) ? scwfc_pkg::RESP_OKAY
                                                             : scwfc_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb
  begin
    rd_data = 32'h0000_0000;
    rd_ok   = 1'b1;
    case (s_axi_araddr)
      scwfc_pkg::ADDR_CTRL:
        rd_data[scwfc_pkg::CTRL_EN_BIT] = ctrl_en_reg;
      scwfc_pkg::ADDR_STATUS_REGISTER:
      begin
        rd_data[NE-1:0]                   = status_reg;
        rd_data[scwfc_pkg::STS_BUSY]      = (st_reg != scwfc_pkg::ST_IDLE);
        rd_data[scwfc_pkg::STS_CS_ACTIVE] = !cs_n_reg;
        rd_data[scwfc_pkg::STS_FIFO_FULL] = fifo_full;
      end
      scwfc_pkg::ADDR_IRQ_MASK:
        rd_data[NE-1:0] = irq_mask_reg;
      scwfc_pkg::ADDR_TRANSMIT_COMMAND_REGISTER:
        rd_data = cmd_reg;
      scwfc_pkg::ADDR_TX_DATA:
        rd_data = 32'h0000_0000;
      scwfc_pkg::ADDR_RX_DATA:
        rd_data = rdr_reg;
      default:
        rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= scwfc_pkg::RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_data;
      s_axi_rresp  <= rd_ok ? scwfc_pkg::RESP_OKAY : scwfc_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Control, mask and interrupt
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_en_reg  <= 1'b0;
      en_d_reg     <= 1'b0;
      irq_mask_reg <= '0;
    end
    else
    begin
      en_d_reg <= ctrl_en_reg;
      if (wr_fire && wstrb_reg[0] && (awaddr_reg == scwfc_pkg::ADDR_CTRL))
        ctrl_en_reg <= wdata_reg[scwfc_pkg::CTRL_EN_BIT];
      if (wr_fire && wstrb_reg[0] && (awaddr_reg == scwfc_pkg::ADDR_IRQ_MASK))
        irq_mask_reg <= wdata_reg[NE-1:0];
    end
  end
  assign en_rise = ctrl_en_reg && !en_d_reg;

  assign ev[scwfc_pkg::STS_FRAME_DONE] = frame_end;
  // Re-enable without soft reset flags stale receive state
  assign ev[scwfc_pkg::STS_RX_ERR] = (lnk.done && rdr_full_reg && !rd_rdr)
                                  || (en_rise && rx_seen_reg);
  assign ev[scwfc_pkg::STS_TX_OVF] = wr_fire && wr_fifo && fifo_full;
  assign w1c = (wr_fire && wstrb_reg[0] && (awaddr_reg == scwfc_pkg::ADDR_STATUS_REGISTER))
             ? wdata_reg[NE-1:0] : '0;

  for (genvar i = 0; i < NE; i++)
  begin : g_sts
    // Set beats a simultaneous clear
    always_ff @(posedge aclk)
    begin
      if (!aresetn || srst)
        status_reg[i] <= 1'b0;
      else if (ev[i])
        status_reg[i] <= 1'b1;
      else if (w1c[i])
        status_reg[i] <= 1'b0;
    end
  end
  assign irq = |(status_reg & irq_mask_reg);

  // Command and data queue
  assign fifo_head  = fifo_mem[rd_ptr_reg[AW-1:0]];
  assign fifo_empty = (wr_ptr_reg == rd_ptr_reg);
  assign fifo_full  = (wr_ptr_reg == {~rd_ptr_reg[AW], rd_ptr_reg[AW-1:0]});

  always_ff @(posedge aclk)
  begin
    if (push)
      fifo_mem[wr_ptr_reg[AW-1:0]] <=
        {awaddr_reg == scwfc_pkg::ADDR_TRANSMIT_COMMAND_REGISTER, wdata_reg};
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || srst)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + (AW+1)'(1);
      if (pop_cmd || pop_data)
        rd_ptr_reg <= rd_ptr_reg + (AW+1)'(1);
    end
  end

  // Frame sequencing
  assign cmd_mask   = cmd_reg[scwfc_pkg::TRANSMIT_MASK_BIT];
  assign cmd_cont   = cmd_reg[scwfc_pkg::CONTINUOUS_TRANSFER_BIT];
  assign frame_bits = {1'b0, cmd_reg[scwfc_pkg::FRAME_SIZE_FIELD_LSB +: FW]}
                    + {{FW{1'b0}}, 1'b1};
  assign n_chunk    = (bits_left_reg >= (FW+1)'(32)) ? 6'h20 : bits_left_reg[5:0];
  // Commands are only taken between frames, so none cuts a frame short
  assign pop_cmd     = (st_reg == scwfc_pkg::ST_IDLE) && ctrl_en_reg && !fifo_empty
                    && fifo_head[32];
  assign start_frame = (st_reg == scwfc_pkg::ST_IDLE) && ctrl_en_reg && !pop_cmd
                    && (cmd_mask || (!fifo_empty && !fifo_head[32]));
  assign chunk_go    = (st_reg == scwfc_pkg::ST_CHUNK)
                    && (cmd_mask || (!fifo_empty && !fifo_head[32]));
  assign pop_data    = chunk_go && !cmd_mask;
  assign frame_end   = (st_reg == scwfc_pkg::ST_SHIFT) && lnk.done
                    && (bits_left_reg == {{(FW-5){1'b0}}, chunk_reg});

  assign lnk.start = chunk_go;
  assign lnk.abort = srst;
  assign lnk.nbits = n_chunk;
  assign lnk.mask  = cmd_mask;
  assign lnk.word  = cmd_mask ? 32'h0000_0000 : (fifo_head[31:0] << (6'h20 - n_chunk));
  assign peripheral_chip_select_n = cs_n_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || srst)
    begin
      st_reg        <= scwfc_pkg::ST_IDLE;
      cmd_reg       <= scwfc_pkg::CMD_RST;
      cs_n_reg      <= 1'b1;
      bits_left_reg <= '0;
      chunk_reg     <= 6'h00;
    end
    else
    begin
      case (st_reg)
        scwfc_pkg::ST_IDLE:
        begin
          if (pop_cmd)
          begin
            cmd_reg  <= fifo_head[31:0];
            cs_n_reg <= 1'b1;
          end
          else if (start_frame)
          begin
            bits_left_reg <= frame_bits;
            cs_n_reg      <= 1'b0;
            st_reg        <= scwfc_pkg::ST_CHUNK;
          end
        end
        scwfc_pkg::ST_CHUNK:
        begin
          if (chunk_go)
          begin
            chunk_reg <= n_chunk;
            st_reg    <= scwfc_pkg::ST_SHIFT;
          end
        end
        scwfc_pkg::ST_SHIFT:
        begin
          if (lnk.done)
          begin
            bits_left_reg <= bits_left_reg - {{(FW-5){1'b0}}, chunk_reg};
            if (frame_end)
            begin
              st_reg <= scwfc_pkg::ST_IDLE;
              if (!cmd_cont)
                cs_n_reg <= 1'b1;
              cmd_reg[scwfc_pkg::TRANSMIT_MASK_BIT] <= 1'b0;
            end
            else
            begin
              st_reg <= scwfc_pkg::ST_CHUNK;
            end
          end
        end
        default:
          st_reg <= scwfc_pkg::ST_IDLE;
      endcase
    end
  end

  // Receive side
  always_ff @(posedge aclk)
  begin
    if (!aresetn || srst)
    begin
      rdr_reg      <= 32'h0000_0000;
      rdr_full_reg <= 1'b0;
      rx_seen_reg  <= 1'b0;
    end
    else if (lnk.done)
    begin
      rdr_reg      <= lnk.rx_word;
      rdr_full_reg <= 1'b1;
      rx_seen_reg  <= 1'b1;
    end
    else if (rd_rdr)
    begin
      rdr_full_reg <= 1'b0;
    end
  end

  scwfc_shifter u_shifter (
    .aclk    (aclk),
    .aresetn (aresetn),
    .sdi     (sdi),
    .sck     (sck),
    .sdo     (sdo),
    .sdo_oe  (sdo_oe),
    .lnk     (lnk.eng)
  );

  // Checks
  logic [FW:0] chk_bits_reg;
  logic        chk_sck_reg;
  always_ff @(posedge aclk)
  begin
    chk_sck_reg <= sck;
    if (!aresetn || start_frame)
      chk_bits_reg <= '0;
    else if (sck && !chk_sck_reg)
      chk_bits_reg <= chk_bits_reg + {{FW{1'b0}}, 1'b1};
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_frame_end;
    frame_end;
  endsequence
  sequence s_cmd_write;
    wr_fire && (awaddr_reg == scwfc_pkg::ADDR_TRANSMIT_COMMAND_REGISTER) && !fifo_full;
  endsequence
  sequence s_reenable;
    en_rise && rx_seen_reg && !srst;
  endsequence

  chk_cmd_read_live: assert property (
    rd_fire && (s_axi_araddr == scwfc_pkg::ADDR_TRANSMIT_COMMAND_REGISTER)
    |=> s_axi_rvalid && (s_axi_rdata == $past(cmd_reg)))
    else $error("command read not live state");
  chk_cmd_queued: assert property (
    s_cmd_write |=> fifo_mem[$past(wr_ptr_reg[AW-1:0])][32]
                    && (wr_ptr_reg != $past(wr_ptr_reg)))
    else $error("command word not queued");
  chk_frame_length: assert property (
    s_frame_end |-> chk_bits_reg == frame_bits)
    else $error("frame length wrong");
  chk_mask_float: assert property (
    cmd_mask && (st_reg != scwfc_pkg::ST_IDLE) |-> !sdo_oe && !pop_data)
    else $error("masked frame drove data or fetched");
  chk_mask_kept: assert property (
    cmd_mask && (st_reg == scwfc_pkg::ST_SHIFT) && !lnk.done && !srst |=> cmd_mask)
    else $error("masked transfer aborted");
  chk_mask_clear: assert property (
    s_frame_end ##0 cmd_mask |=> !cmd_mask)
    else $error("mask not cleared at end");
  chk_cont_hold: assert property (
    s_frame_end ##0 (cmd_cont && !srst) |=> !peripheral_chip_select_n)
    else $error("chip select dropped in continuous mode");
  chk_no_early_drop: assert property (
    st_reg != scwfc_pkg::ST_IDLE |-> !peripheral_chip_select_n)
    else $error("chip select dropped mid frame");
  chk_reenable_err: assert property (
    s_reenable |=> status_reg[scwfc_pkg::STS_RX_ERR]
                   ##1 (irq || !irq_mask_reg[scwfc_pkg::STS_RX_ERR]))
    else $error("receive error not set on re-enable");
endmodule

// [sim/scwfc_slave_model.sv]
/*
  Serial device stand-in: counts bits, captures sdo, answers a fixed word.
  Assumes mode 0, active-low select, MSB first, one frame per select window.
*/
`timescale 1ns/1ns
module scwfc_slave_model (
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic        sdo,
  input  wire logic        sdo_oe,
  input  wire logic [31:0] reply,
  output logic             sdi,
  output logic [31:0]      rx,
  output int               nbits,
  output int               nfloat
);
  int idx;

  initial sdi = 1'b0;

  always @(negedge cs_n)
  begin
    nbits = 0;
    nfloat = 0;
    idx = 31;
    sdi = reply[31];
  end

  // A released sdo is never read, so a float cannot pass as data
  always @(posedge sck)
    if (!cs_n)
    begin
      nbits++;
      if (sdo_oe) rx = {rx[30:0], sdo};
      else nfloat++;
    end

  always @(negedge sck)
    if (!cs_n)
    begin
      idx = (idx + 31) % 32;
      sdi = reply[idx];
    end

  // No pull on the line: show the inverse, not a stale level
  always @(posedge cs_n) sdi = ~sdi;
endmodule

// [sim/scwfc_top_tb.sv]
/*
  Bench for the command-word frame controller: AXI4-Lite master tasks,
  one task per scenario, serial device model on the link pins.
  Assumes the register map and timing of the controller package.
*/
`timescale 1ns/1ns
module scwfc_top_tb;
  localparam logic [7:0]  CTL   = scwfc_pkg::ADDR_CTRL;
  localparam logic [7:0]  STS   = scwfc_pkg::ADDR_STATUS_REGISTER;
  localparam logic [7:0]  MSK   = scwfc_pkg::ADDR_IRQ_MASK;
  localparam logic [7:0]  CMD   = scwfc_pkg::ADDR_TRANSMIT_COMMAND_REGISTER;
  localparam logic [7:0]  TXD   = scwfc_pkg::ADDR_TX_DATA;
  localparam logic [7:0]  RXD   = scwfc_pkg::ADDR_RX_DATA;
  localparam logic [31:0] REPLY = 32'hB4E1_7A29;
  logic        aclk    = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr  = 8'h00;
  logic [7:0]  araddr  = 8'h00;
  logic [31:0] wdata   = 32'h0000_0000;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        sck, cs_n, sdo, sdo_oe, sdi, irq;
  logic [1:0]  bresp, rresp, rsp;
  logic [31:0] rdata, rx, v;
  int          nbits, nfloat;
  int          num_errors = 0;
  int          checks     = 0;

  always #25 aclk = ~aclk;

  scwfc_top scwfc_top_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sck(sck), .peripheral_chip_select_n(cs_n), .sdo(sdo), .sdo_oe(sdo_oe), .sdi(sdi),
    .irq(irq)
  );

  scwfc_slave_model scwfc_slave_model_i (
    .sck(sck), .cs_n(cs_n), .sdo(sdo), .sdo_oe(sdo_oe), .reply(REPLY), .sdi(sdi),
    .rx(rx), .nbits(nbits), .nfloat(nfloat)
  );

  task automatic complete_run;
    $display("checks %0d, errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_up;
    num_errors++;
    complete_run;
  endtask

  // Each channel drops its valid at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    repeat (50)
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        rsp = bresp;
        bready <= 1'b0;
        return;
      end
    end
    give_up;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    repeat (50)
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        v = rdata;
        rsp = rresp;
        rready <= 1'b0;
        return;
      end
    end
    give_up;
  endtask

  task automatic wait_irq;
    repeat (1000)
    begin
      @(posedge aclk);
      if (irq === 1'b1) return;
    end
    give_up;
  endtask

  task automatic t_regs;
    rd(CMD);
    chk(v, scwfc_pkg::CMD_RST);
    rd(8'h20);
    chk(32'(rsp), 32'(scwfc_pkg::RESP_SLVERR));
    chk(v, 32'h0000_0000);
    wr(8'h20, 32'h0000_0001);
    chk(32'(rsp), 32'(scwfc_pkg::RESP_SLVERR));
    wr(RXD, 32'h0000_0001);
    chk(32'(rsp), 32'(scwfc_pkg::RESP_SLVERR));
    wr(MSK, 32'h0000_0001);
    wr(CTL, 32'h0000_0001);
  endtask

  task automatic t_frames;
    wr(CMD, 32'h0000_0007);
    wr(TXD, 32'h0000_01A5);
    wr(CMD, 32'h0000_0003);
    wr(TXD, 32'h0000_00BC);
    wait_irq;
    chk(32'(nbits), 32'h0000_0008);
    chk(32'(rx[7:0]), 32'h0000_00A5);
    chk(32'(nfloat), 32'h0000_0000);
    rd(RXD);
    chk(v, 32'h0000_00B4);
    wr(STS, 32'h0000_0007);
    wait_irq;
    chk(32'(nbits), 32'h0000_0004);
    chk(32'(rx[3:0]), 32'h0000_000C);
    chk(32'(cs_n), 32'h0000_0001);
  endtask

  task automatic t_masked;
    wr(STS, 32'h0000_0007);
    wr(CMD, 32'h0040_0027);
    wait_irq;
    chk(32'(nbits), 32'h0000_0028);
    chk(32'(nfloat), 32'h0000_0028);
    chk(32'(cs_n), 32'h0000_0001);
    rd(STS);
    rd(CMD);
    chk(v, 32'h0000_0027);
  endtask

  // Long masked transfer split into chained commands; the second waits its turn
  task automatic t_split;
    wr(STS, 32'h0000_0007);
    wr(CMD, 32'h0050_001F);
    wr(CMD, 32'h0040_0007);
    wait_irq;
    chk(32'(nbits), 32'h0000_0020);
    chk(32'(nfloat), 32'h0000_0020);
    chk(32'(cs_n), 32'h0000_0000);
    wr(STS, 32'h0000_0007);
    wait_irq;
    chk(32'(nbits), 32'h0000_0008);
    chk(32'(nfloat), 32'h0000_0008);
    chk(32'(cs_n), 32'h0000_0001);
    rd(CMD);
    chk(v, 32'h0000_0007);
  endtask

  task automatic t_contin;
    wr(STS, 32'h0000_0007);
    wr(CMD, 32'h0010_0007);
    wr(TXD, 32'h0000_003C);
    wait_irq;
    wr(STS, 32'h0000_0007);
    chk(32'(cs_n), 32'h0000_0000);
    chk(32'(rx[7:0]), 32'h0000_003C);
    rd(CMD);
    chk(v, 32'h0010_0007);
    wr(CMD, 32'h0000_0007);
    for (int n = 0; n < 20 && cs_n !== 1'b1; n++) @(posedge aclk);
    chk(32'(cs_n), 32'h0000_0001);
    wr(TXD, 32'h0000_0081);
    wait_irq;
    chk(32'(nbits), 32'h0000_0008);
    chk(32'(rx[7:0]), 32'h0000_0081);
  endtask

  task automatic t_rxerr;
    wr(STS, 32'h0000_0007);
    wr(CTL, 32'h0000_0000);
    wr(CTL, 32'h0000_0001);
    rd(STS);
    chk(32'(v[1]), 32'h0000_0001);
    wr(STS, 32'h0000_0002);
    rd(STS);
    chk(32'(v[1]), 32'h0000_0000);
    wr(CTL, 32'h0000_0003);
    wr(CTL, 32'h0000_0000);
    wr(CTL, 32'h0000_0001);
    rd(STS);
    chk(32'(v[1]), 32'h0000_0000);
    rd(CMD);
    chk(v, scwfc_pkg::CMD_RST);
  endtask

  // Queue filled with the engine stopped, so nothing drains it
  task automatic t_ovf;
    wr(CTL, 32'h0000_0000);
    repeat (4) wr(TXD, 32'h0000_0055);
    chk(32'(rsp), 32'(scwfc_pkg::RESP_OKAY));
    wr(TXD, 32'h0000_0055);
    chk(32'(rsp), 32'(scwfc_pkg::RESP_SLVERR));
    rd(STS);
    chk(v & 32'h0000_0404, 32'h0000_0404);
    chk(32'(irq), 32'h0000_0000);
    wr(MSK, 32'h0000_0004);
    chk(32'(irq), 32'h0000_0001);
    wr(STS, 32'h0000_0004);
    chk(32'(irq), 32'h0000_0000);
    wr(CTL, 32'h0000_0002);
  endtask

  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_frames;
    t_masked;
    t_split;
    t_contin;
    t_rxerr;
    t_ovf;
    complete_run;
  end
endmodule
